//--- rtl/bsc_section_codec.sv
// section line codec top: encoder, decoder with clock recovery, loss detect, registers
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
module bsc_section_codec (
  // clock and reset
  input  wire logic         CLK,
  input  wire logic         RSTN,
  // payload source side
  input  wire logic         PAYLOAD_CLOCK,
  input  wire logic         PAYLOAD_DATA,
  // line transmit
  output logic              LINE_POS,
  output logic              LINE_NEG,
  output logic              LINE_CLOCK,
  // line receive
  input  wire logic         RX_POS,
  input  wire logic         RX_NEG,
  // payload sink side
  output logic              SECTION_DATA,
  output logic              RECOVERED_CLOCK,
  output logic              SERVER_FAIL,
  output logic              TRAIL_FAIL,
  output logic              LOSS_FAULT,
  // register port
  input  wire logic [7:0]   REG_ADDR,
  input  wire logic [31:0]  REG_WDATA,
  input  wire logic         REG_WR,
  input  wire logic         REG_RD,
  output logic [31:0]       REG_RDATA,
  output logic              IRQ
);

  // reset release synchroniser
  logic rst_meta, rst_n;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pin synchronisers, two stages then one edge stage
  logic [1:0] pclk_s, pdat_s, rxp_s, rxn_s;
  logic       pclk_d, pdat_d, rx_mark_d;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pclk_s    <= 2'b00;
      pdat_s    <= 2'b00;
      rxp_s     <= 2'b00;
      rxn_s     <= 2'b00;
      pclk_d    <= 1'b0;
      pdat_d    <= 1'b0;
      rx_mark_d <= 1'b0;
    end else begin
      pclk_s    <= {pclk_s[0], PAYLOAD_CLOCK};
      pdat_s    <= {pdat_s[0], PAYLOAD_DATA};
      rxp_s     <= {rxp_s[0], RX_POS};
      rxn_s     <= {rxn_s[0], RX_NEG};
      pclk_d    <= pclk_s[1];
      pdat_d    <= pdat_s[1];
      rx_mark_d <= rxp_s[1] | rxn_s[1];
    end
  end

  // transmit path: payload bit taken on each payload clock rising edge
  logic              tx_stb;
  bsc_pkg::bsc_sym_t tx_sym;
  assign tx_stb = pclk_s[1] & ~pclk_d;

  bsc_encoder u_encoder (
    .clk     (CLK),
    .rst_n   (rst_n),
    .bit_stb (tx_stb),
    .bit_in  (pdat_d),
    .sym_out (tx_sym)
  );

  // line outputs follow the delayed payload clock with constant latency
  logic next_line_clock;
  assign next_line_clock = pclk_d;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      LINE_POS   <= 1'b0;
      LINE_NEG   <= 1'b0;
      LINE_CLOCK <= 1'b0;
    end else begin
      LINE_POS   <= tx_sym.pos;
      LINE_NEG   <= tx_sym.neg;
      LINE_CLOCK <= next_line_clock;
    end
  end

  // receive clock recovery: nco re-phased on each mark leading edge
  logic [31:0] phase, next_phase;
  logic        mark_edge, tick, next_tick;
  assign mark_edge = (rxp_s[1] | rxn_s[1]) & ~rx_mark_d;
  always_comb begin
    next_phase = phase + bsc_pkg::NCO_INC;
    next_tick  = 1'b0;
    if (mark_edge) begin
      next_phase = bsc_pkg::NCO_REALIGN;
    end else if (!phase[31] && next_phase[31]) begin
      next_tick = 1'b1;                                 // bit centre
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 32'h0000_0000;
      tick  <= 1'b0;
    end else begin
      phase <= next_phase;
      tick  <= next_tick;
    end
  end

  // decoder: a violation clears itself and the two bits before it
  logic [2:0] dq, next_dq;
  logic       last_pos, next_last_pos, seen, next_seen;
  logic       viol, rx_bit, smp_mark;
  always_comb begin
    smp_mark      = rxp_s[1] | rxn_s[1];
    viol          = smp_mark && seen && (rxp_s[1] == last_pos);
    rx_bit        = smp_mark && !viol;
    next_dq       = dq;
    next_last_pos = last_pos;
    next_seen     = seen;
    if (tick) begin
      if (viol) begin
        next_dq = {1'b0, 1'b0, 1'b0};
      end else begin
        next_dq = {dq[1], dq[0], rx_bit};
      end
      if (smp_mark) begin
        next_last_pos = rxp_s[1];
        next_seen     = 1'b1;
      end
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dq       <= 3'b000;
      last_pos <= 1'b0;
      seen     <= 1'b0;
    end else begin
      dq       <= next_dq;
      last_pos <= next_last_pos;
      seen     <= next_seen;
    end
  end

  // loss detector: long zero run declares, a clean stretch clears
  bsc_pkg::bsc_los_state_t los_st, next_los_st;
  logic [7:0] zrun, next_zrun, clr_cnt, next_clr_cnt;
  logic       run_hit;
  always_comb begin
    next_los_st  = los_st;
    next_zrun    = zrun;
    next_clr_cnt = clr_cnt;
    run_hit      = (zrun >= 8'(bsc_pkg::LOS_ZERO_RUN - 1));
    if (tick) begin
      if (smp_mark) begin
        next_zrun = 8'd0;
      end else if (!run_hit) begin
        next_zrun = zrun + 8'd1;
      end
      case (los_st)
        bsc_pkg::LOS_GOOD: begin
          next_clr_cnt = 8'd0;
          if (!smp_mark && run_hit) begin
            next_los_st = bsc_pkg::LOS_LOST;
          end
        end
        bsc_pkg::LOS_LOST: begin
          if (!smp_mark && run_hit) begin
            next_clr_cnt = 8'd0;
          end else if (clr_cnt == 8'(bsc_pkg::LOS_CLEAR_BITS - 1)) begin
            next_los_st = bsc_pkg::LOS_GOOD;
          end else begin
            next_clr_cnt = clr_cnt + 8'd1;
          end
        end
        default: next_los_st = bsc_pkg::LOS_GOOD;
      endcase
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      los_st  <= bsc_pkg::LOS_GOOD;
      zrun    <= 8'd0;
      clr_cnt <= 8'd0;
    end else begin
      los_st  <= next_los_st;
      zrun    <= next_zrun;
      clr_cnt <= next_clr_cnt;
    end
  end

  // alarm signal source, timed by the recovered or free-running bit tick
  logic ais_bit;
  bsc_ais_gen u_ais (
    .clk     (CLK),
    .rst_n   (rst_n),
    .tick    (tick),
    .ais_bit (ais_bit)
  );

  // defects, consequent actions and sink outputs
  logic              mon, next_mon;
  logic              los;
  bsc_pkg::bsc_alarm_t alm;
  logic              next_data;
  assign los = (los_st == bsc_pkg::LOS_LOST);
  always_comb begin
    alm.signal_loss      = los;
    alm.trail_fail       = los;
    alm.server_fail      = alm.trail_fail;
    alm.loss_fault_cause = mon & los;
    next_data            = SECTION_DATA;
    if (tick) begin
      next_data = alm.trail_fail ? ais_bit : dq[2];
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SECTION_DATA    <= 1'b0;
      RECOVERED_CLOCK <= 1'b0;
      SERVER_FAIL     <= 1'b0;
      TRAIL_FAIL      <= 1'b0;
      LOSS_FAULT      <= 1'b0;
    end else begin
      SECTION_DATA    <= next_data;
      RECOVERED_CLOCK <= ~phase[31];
      SERVER_FAIL     <= alm.server_fail;
      TRAIL_FAIL      <= alm.trail_fail;
      LOSS_FAULT      <= alm.loss_fault_cause;
    end
  end

  // register file, interrupt status and mask
  logic [bsc_pkg::EV_WIDTH-1:0] ist, next_ist, imask, next_imask, ev;
  logic [31:0]                  next_rdata;
  logic                         los_q, next_irq, irq_q;
  always_comb begin
    ev                          = '0;
    ev[bsc_pkg::EV_LOS_SET]     = los & ~los_q;
    ev[bsc_pkg::EV_LOS_CLR]     = ~los & los_q;
    ev[bsc_pkg::EV_VIOL]        = tick & viol;
    next_mon   = mon;
    next_imask = imask;
    next_ist   = ist;
    next_rdata = 32'h0000_0000;
    if (REG_WR) begin
      if (REG_ADDR == bsc_pkg::REG_CTRL) begin
        next_mon = REG_WDATA[bsc_pkg::CTRL_MON_BIT];
      end else if (REG_ADDR == bsc_pkg::REG_INT_STATUS) begin
        next_ist = ist & ~REG_WDATA[bsc_pkg::EV_WIDTH-1:0];
      end else if (REG_ADDR == bsc_pkg::REG_INT_MASK) begin
        next_imask = REG_WDATA[bsc_pkg::EV_WIDTH-1:0];
      end
    end
    next_ist = next_ist | ev;                           // set wins over clear
    if (REG_RD) begin
      if (REG_ADDR == bsc_pkg::REG_CTRL) begin
        next_rdata[bsc_pkg::CTRL_MON_BIT] = mon;
      end else if (REG_ADDR == bsc_pkg::REG_STATUS) begin
        next_rdata[bsc_pkg::ST_LOS_BIT]  = alm.signal_loss;
        next_rdata[bsc_pkg::ST_TSF_BIT]  = alm.trail_fail;
        next_rdata[bsc_pkg::ST_LOSS_FAULT_CAUSE_BIT] = alm.loss_fault_cause;
        next_rdata[bsc_pkg::ST_SSF_BIT]  = alm.server_fail;
      end else if (REG_ADDR == bsc_pkg::REG_INT_STATUS) begin
        next_rdata[bsc_pkg::EV_WIDTH-1:0] = ist;
      end else if (REG_ADDR == bsc_pkg::REG_INT_MASK) begin
        next_rdata[bsc_pkg::EV_WIDTH-1:0] = imask;
      end
    end
    next_irq = |(next_ist & next_imask);
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mon       <= bsc_pkg::CTRL_MON_RST;
      imask     <= bsc_pkg::INT_MASK_RST;
      ist       <= '0;
      los_q     <= 1'b0;
      irq_q     <= 1'b0;
      REG_RDATA <= 32'h0000_0000;
    end else begin
      mon       <= next_mon;
      imask     <= next_imask;
      ist       <= next_ist;
      los_q     <= los;
      irq_q     <= next_irq;
      REG_RDATA <= next_rdata;
    end
  end
  assign IRQ = irq_q;

endmodule : bsc_section_codec

//--- rtl/bsc_pkg.sv
// shared constants and types for the bipolar section line codec
package bsc_pkg;

  // clock and line rates
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned LINE_RATE_KHZ  = 44736;
  // nco step per clock: line rate over clock rate, scaled by 2^32
  localparam logic [31:0] NCO_INC        = 32'((64'(LINE_RATE_KHZ) << 32) / 64'(CLK_KHZ));
  // phase loaded on a mark edge: the next step crosses half scale, so the
  // sample lands two clocks after the synced edge, mid-symbol, not at its end
  localparam logic [31:0] NCO_REALIGN    = 32'h8000_0000 - NCO_INC;

  // loss of signal thresholds, in bit periods
  localparam int unsigned LOS_ZERO_RUN   = 175;
  localparam int unsigned LOS_CLEAR_BITS = 175;

  // alarm frame geometry: 7 subframes of 8 blocks of 85 bits
  localparam int unsigned AIS_BLOCK_BITS = 85;
  localparam int unsigned AIS_BLOCKS     = 8;
  localparam int unsigned AIS_SUBFRAMES  = 7;

  // register offsets
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h04;
  localparam logic [7:0] REG_INT_STATUS  = 8'h08;
  localparam logic [7:0] REG_INT_MASK    = 8'h0C;

  // field positions
  localparam int unsigned CTRL_MON_BIT   = 0;
  localparam int unsigned ST_LOS_BIT     = 0;
  localparam int unsigned ST_TSF_BIT     = 1;
  localparam int unsigned ST_LOSS_FAULT_CAUSE_BIT    = 2;
  localparam int unsigned ST_SSF_BIT     = 3;
  localparam int unsigned EV_LOS_SET     = 0;
  localparam int unsigned EV_LOS_CLR     = 1;
  localparam int unsigned EV_VIOL        = 2;
  localparam int unsigned EV_WIDTH       = 3;

  // reset values
  localparam logic       CTRL_MON_RST    = 1'b1;
  localparam logic [2:0] INT_MASK_RST    = 3'h0;

  // one bipolar line symbol as two rails
  typedef struct packed {
    logic pos;
    logic neg;
  } bsc_sym_t;

  // defect and fail indications
  typedef struct packed {
    logic loss_fault_cause;
    logic server_fail;
    logic trail_fail;
    logic signal_loss;
  } bsc_alarm_t;

  // loss detector states
  typedef enum logic [1:0] {
    LOS_GOOD = 2'b01,
    LOS_LOST = 2'b10
  } bsc_los_state_t;

endpackage : bsc_pkg

//--- rtl/bsc_encoder.sv
// three-zero substitution encoder from payload bits to bipolar symbols
module bsc_encoder (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // payload bit in
  input  wire logic          bit_stb,
  input  wire logic          bit_in,
  // symbol out
  output bsc_pkg::bsc_sym_t  sym_out
);

  bsc_pkg::bsc_sym_t p0, p1, p2, next_p0, next_p1, next_p2;
  bsc_pkg::bsc_sym_t out_q, next_out;
  logic              last_pos, next_last_pos;
  logic              odd, next_odd;
  logic [1:0]        zc, next_zc;

  // substitution decision for each incoming bit
  always_comb begin
    next_p0       = p0;
    next_p1       = p1;
    next_p2       = p2;
    next_out      = out_q;
    next_last_pos = last_pos;
    next_odd      = odd;
    next_zc       = zc;
    if (bit_stb) begin
      next_out = p2;
      next_p2  = p1;
      next_p1  = p0;
      if (bit_in) begin
        next_last_pos = ~last_pos;
        next_p0       = '{pos: ~last_pos, neg: last_pos};
        next_odd      = ~odd;
        next_zc       = 2'd0;
      end else if (zc == 2'd2) begin
        next_zc  = 2'd0;
        next_odd = 1'b0;
        if (odd) begin
          next_p0 = '{pos: last_pos, neg: ~last_pos};    // 00V
        end else begin
          next_last_pos = ~last_pos;
          next_p2 = '{pos: ~last_pos, neg: last_pos};    // B0V
          next_p0 = '{pos: ~last_pos, neg: last_pos};
        end
      end else begin
        next_zc = zc + 2'd1;
        next_p0 = '{pos: 1'b0, neg: 1'b0};
      end
    end
  end

  // state clears on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p0       <= '0;
      p1       <= '0;
      p2       <= '0;
      out_q    <= '0;
      last_pos <= 1'b0;
      odd      <= 1'b0;
      zc       <= 2'd0;
    end else begin
      p0       <= next_p0;
      p1       <= next_p1;
      p2       <= next_p2;
      out_q    <= next_out;
      last_pos <= next_last_pos;
      odd      <= next_odd;
      zc       <= next_zc;
    end
  end

  assign sym_out = out_q;

endmodule : bsc_encoder

//--- rtl/bsc_ais_gen.sv
// alarm signal generator with valid frame, subframe and parity bits
module bsc_ais_gen (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // bit timing
  input  wire logic  tick,
  // alarm bit out
  output logic       ais_bit
);

  logic [6:0] bitn, next_bitn;
  logic [2:0] blk, next_blk;
  logic [2:0] sf, next_sf;
  logic       par, next_par;
  logic       pbit, next_pbit;
  logic       out_q, next_out;
  logic       ovh;

  // frame position, overhead values and parity of info bits
  always_comb begin
    next_bitn = bitn;
    next_blk  = blk;
    next_sf   = sf;
    next_par  = par;
    next_pbit = pbit;
    next_out  = out_q;
    ovh       = 1'b0;
    if (tick) begin
      if (bitn == 7'd0) begin
        if (blk == 3'd0) begin
          if (sf < 3'd2) begin
            ovh = 1'b1;                                  // x bits one
          end else if (sf < 3'd4) begin
            ovh = pbit;                                  // parity
          end else begin
            ovh = (sf == 3'd5);                          // m pattern 010
          end
        end else if (blk[0]) begin
          ovh = (blk == 3'd1) || (blk == 3'd7);          // f pattern 1001
        end else begin
          ovh = 1'b0;                                    // c bits zero
        end
        next_out = ovh;
      end else begin
        next_out = bitn[0];                              // 10 after overhead
        next_par = par ^ bitn[0];
      end
      if (bitn == 7'(bsc_pkg::AIS_BLOCK_BITS - 1)) begin
        next_bitn = 7'd0;
        if (blk == 3'(bsc_pkg::AIS_BLOCKS - 1)) begin
          next_blk = 3'd0;
          if (sf == 3'(bsc_pkg::AIS_SUBFRAMES - 1)) begin
            next_sf   = 3'd0;
            next_pbit = next_par;
            next_par  = 1'b0;
          end else begin
            next_sf = sf + 3'd1;
          end
        end else begin
          next_blk = blk + 3'd1;
        end
      end else begin
        next_bitn = bitn + 7'd1;
      end
    end
  end

  // frame counters register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitn  <= 7'd0;
      blk   <= 3'd0;
      sf    <= 3'd0;
      par   <= 1'b0;
      pbit  <= 1'b0;
      out_q <= 1'b1;
    end else begin
      bitn  <= next_bitn;
      blk   <= next_blk;
      sf    <= next_sf;
      par   <= next_par;
      pbit  <= next_pbit;
      out_q <= next_out;
    end
  end

  assign ais_bit = out_q;

endmodule : bsc_ais_gen

//--- verif/bsc_section_checker.sv
// port assertions for the section line codec top
module bsc_section_checker (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // line transmit
  input wire logic        LINE_POS,
  input wire logic        LINE_NEG,
  // alarm levels
  input wire logic        SERVER_FAIL,
  input wire logic        TRAIL_FAIL,
  input wire logic        LOSS_FAULT,
  // register port
  input wire logic [7:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 100fs;
  logic mon;
  logic next_mon;
  wire  rd_ctrl = REG_RD && (REG_ADDR == bsc_pkg::REG_CTRL);
  // shadow of the monitor bit as software writes it
  always_comb begin
    next_mon = mon;
    if (REG_WR && REG_ADDR == bsc_pkg::REG_CTRL) next_mon = REG_WDATA[0];
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) mon <= bsc_pkg::CTRL_MON_RST;
    else mon <= next_mon;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_rails_exclusive: assert property (!(LINE_POS && LINE_NEG))
    else $error("both line rails high");
  a_server_trail_same: assert property (SERVER_FAIL == TRAIL_FAIL)
    else $error("server fail differs from trail fail");
  a_fault_when_mon: assert property ((mon && TRAIL_FAIL) [*3] |-> LOSS_FAULT)
    else $error("loss fault missing while monitored");
  a_fault_gated_off: assert property ((!mon || !TRAIL_FAIL) [*3] |-> !LOSS_FAULT)
    else $error("loss fault while not reportable");
  a_fail_holds: assert property ($rose(TRAIL_FAIL) |-> TRAIL_FAIL [*8])
    else $error("trail fail dropped early");
  a_reset_quiet: assert property ($rose(RSTN) |-> (!TRAIL_FAIL && !LOSS_FAULT) [*8])
    else $error("alarm high right after reset");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_ctrl_readback: assert property ($past(rd_ctrl) |-> REG_RDATA == {31'h0000_0000, $past(mon)})
    else $error("control readback wrong");
endmodule : bsc_section_checker

bind bsc_section_codec bsc_section_checker u_chk (
  .CLK(CLK), .RSTN(RSTN), .LINE_POS(LINE_POS), .LINE_NEG(LINE_NEG),
  .SERVER_FAIL(SERVER_FAIL), .TRAIL_FAIL(TRAIL_FAIL), .LOSS_FAULT(LOSS_FAULT),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA)
);

//--- verif/bsc_far_end.sv
// far side model: payload source and line loopback
module bsc_far_end #(
  parameter real HALF_NS = 11.1767
) (
  // bench control
  input  wire logic        link_up,
  input  wire logic [31:0] pattern,
  // payload source
  output logic             pclk,
  output logic             pdata,
  // line loopback
  input  wire logic        tx_pos,
  input  wire logic        tx_neg,
  output logic             rx_pos,
  output logic             rx_neg
);
  timeunit 1ns;
  timeprecision 100fs;
  int idx = 0;
  // payload clock near nominal rate, data moved on its falling edge
  initial begin
    pclk = 1'b0;
    pdata = 1'b0;
    forever begin
      #(HALF_NS) pclk = 1'b1;
      #(HALF_NS) pclk = 1'b0;
      pdata = pattern[idx];
      idx = (idx + 1) % 32;
    end
  end
  // line loops back; a cut line carries no marks at all
  assign rx_pos = link_up & tx_pos;
  assign rx_neg = link_up & tx_neg;
endmodule : bsc_far_end

//--- verif/bsc_section_codec_tb.sv
// self-checking bench for the section line codec
`define CHK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, got); \
  end \
end
module bsc_section_codec_tb;
  timeunit 1ns;
  timeprecision 100fs;
  logic        clk, rst_n, pclk, pdata, line_pos, line_neg, line_clk, rx_pos, rx_neg;
  logic        sec_data, rec_clk, server_fail, trail_fail, loss_fault, irq;
  logic        reg_wr, reg_rd, link_up;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pattern;
  int          error_cnt = 0;
  int          check_count = 0;
  bsc_section_codec dut (
    .CLK(clk), .RSTN(rst_n), .PAYLOAD_CLOCK(pclk), .PAYLOAD_DATA(pdata),
    .LINE_POS(line_pos), .LINE_NEG(line_neg), .LINE_CLOCK(line_clk),
    .RX_POS(rx_pos), .RX_NEG(rx_neg), .SECTION_DATA(sec_data), .RECOVERED_CLOCK(rec_clk),
    .SERVER_FAIL(server_fail), .TRAIL_FAIL(trail_fail), .LOSS_FAULT(loss_fault),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .IRQ(irq)
  );
  bsc_far_end #(.HALF_NS(11.1769)) far (                      // near -20 ppm
    .link_up(link_up), .pattern(pattern), .pclk(pclk), .pdata(pdata),
    .tx_pos(line_pos), .tx_neg(line_neg), .rx_pos(rx_pos), .rx_neg(rx_neg)
  );
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // one write strobe cycle
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write
  // one read strobe cycle, data taken in the following cycle
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  task automatic reg_check(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    reg_read(a, d);
    `CHK(nm, e, d)
  endtask : reg_check
  // 64 decoded bits taken mid-bit on the recovered clock
  task automatic grab(output logic [63:0] r);
    for (int i = 0; i < 64; i++) begin
      @(posedge rec_clk);
      #1 r[i] = sec_data;
    end
  endtask : grab
  // received stream equals the repeating pattern at some phase
  function automatic logic rot_match(logic [63:0] r, logic [31:0] p);
    logic [63:0] e;
    for (int k = 0; k < 32; k++) begin
      for (int i = 0; i < 64; i++) e[i] = p[(i + k) % 32];
      if (e === r) return 1'b1;
    end
    return 1'b0;
  endfunction : rot_match
  // neighbours with equal value; alternating info bits give few
  function automatic int same_pairs(logic [63:0] r);
    int n = 0;
    for (int i = 1; i < 64; i++) n += int'(r[i] === r[i-1]);
    return n;
  endfunction : same_pairs
  // main sequence
  initial begin
    logic [31:0] d;
    logic [63:0] r;
    int          n, run, mx;
    realtime     t0;
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    link_up = 1'b1;
    pattern = 32'h8000_0001;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    reg_check(bsc_pkg::REG_CTRL, 32'h0000_0001, "ctrl");
    reg_check(bsc_pkg::REG_INT_MASK, 32'h0000_0000, "mask");
    reg_check(bsc_pkg::REG_STATUS, 32'h0000_0000, "status");
    reg_write(8'h10, 32'hFFFF_FFFF);
    reg_check(8'h10, 32'h0000_0000, "unmapped");
    $display("test reset done");
    repeat (400) @(posedge clk);
    grab(r);
    `CHK("sparse data", 1'b1, rot_match(r, pattern))
    @(posedge clk);
    pattern <= 32'h0000_0000;
    repeat (400) @(posedge clk);
    grab(r);
    `CHK("zero data", 64'h0000_0000_0000_0000, r)
    {run, mx} = '0;
    @(negedge line_clk);
    t0 = $realtime;
    repeat (30) begin
      @(negedge line_clk);
      run = (line_pos || line_neg) ? 0 : run + 1;
      mx = (run > mx) ? run : mx;
    end
    `CHK("line zero run", 1'b1, mx <= 2)
    `CHK("line clock span", 1'b1, ($realtime - t0) > 660.0 && ($realtime - t0) < 680.0)
    `CHK("no false loss", 1'b0, trail_fail)
    $display("test data path done");
    reg_write(bsc_pkg::REG_INT_STATUS, 32'h0000_0007);
    reg_write(bsc_pkg::REG_INT_MASK, 32'h0000_0001);
    link_up <= 1'b0;
    repeat (600) @(negedge clk);
    `CHK("early loss", 1'b0, trail_fail)
    `CHK("early irq", 1'b0, irq)
    for (n = 0; n < 400 && trail_fail !== 1'b1; n++) @(negedge clk);
    reg_check(bsc_pkg::REG_STATUS, 32'h0000_000F, "status loss");
    `CHK("server fail", 1'b1, server_fail)
    `CHK("irq on loss", 1'b1, irq)
    reg_write(bsc_pkg::REG_INT_STATUS, 32'h0000_0001);
    reg_read(bsc_pkg::REG_INT_STATUS, d);
    `CHK("loss event cleared", 1'b0, d[bsc_pkg::EV_LOS_SET])
    `CHK("irq cleared", 1'b0, irq)
    grab(r);
    `CHK("alarm pattern", 1'b1, same_pairs(r) <= 1)
    reg_write(bsc_pkg::REG_CTRL, 32'h0000_0000);
    repeat (3) @(negedge clk);
    `CHK("fault unmonitored", 1'b0, loss_fault)
    `CHK("trail kept", 1'b1, trail_fail)
    reg_write(bsc_pkg::REG_CTRL, 32'h0000_0001);
    $display("test loss done");
    reg_write(bsc_pkg::REG_INT_MASK, 32'h0000_0002);
    pattern <= 32'h8000_0001;
    link_up <= 1'b1;
    for (n = 0; n < 1200 && trail_fail !== 1'b0; n++) @(negedge clk);
    `CHK("trail cleared", 1'b0, trail_fail)
    reg_read(bsc_pkg::REG_INT_STATUS, d);
    `CHK("clear event", 1'b1, d[bsc_pkg::EV_LOS_CLR])
    `CHK("irq on clear", 1'b1, irq)
    repeat (300) @(posedge clk);
    grab(r);
    `CHK("data back", 1'b1, rot_match(r, pattern))
    $display("test restore done");
    stop_test();
  end
  // cut a hang short well past the planned run length
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule : bsc_section_codec_tb
